// ===== src/ext_bus_pkg.sv
// constants and carrier types for the external bus port
// Behaviour
// - 32-bit bidirectional tri-stateable data bus to all external devices
// - drive low only strobes of byte lanes actually used
// - strobe 0 is the most significant byte, strobe 3 the least
// - strobes asserted for on-chip peripheral accesses, not on-chip SRAM or cache
// - during SDRAM accesses strobe pins carry SDRAM byte masks, active high
// - output enable asserted during reads when external device may drive data
// - acknowledge ends the cycle; on reads data is latched first
// - direction output high for read, low for write
// - transfer start output marks the beginning of each transfer
// - six chip-select outputs select external devices
// - external bus clock is half the system clock
// - type select negated: upper 16 pins DDR only, lower 16 bus only
// - config enable decides whether low data pins feed configuration at reset
// - type select asserted means SDR mode, negated means DDR mode
package ext_bus_pkg;
  localparam int ADDR_W     = 24;
  localparam int DATA_W     = 32;
  localparam int LANES      = 4;
  localparam int NUM_CS     = 6;
  localparam int HALF_W     = 16;
  localparam logic [LANES-1:0]  STROBE_IDLE_N = 4'hf;
  localparam logic [LANES-1:0]  MASK_IDLE     = 4'h0;
  localparam logic [NUM_CS-1:0] CS_IDLE_N     = 6'h3f;

  // access target kinds
  typedef enum logic [1:0] {
    TGT_EXT    = 2'h0,
    TGT_PERIPH = 2'h1,
    TGT_ONCHIP = 2'h2,
    TGT_SDRAM  = 2'h3
  } target_t;

  typedef struct packed {
    logic [31:0]       addr;
    logic [DATA_W-1:0] wdata;
    logic [LANES-1:0]  lanes;
    logic              read;
    logic [2:0]        cs_index;
    target_t           target;
  } bus_req_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [NUM_CS-1:0] cs_n;
    logic [LANES-1:0]  strobe;
    logic              dir_read;
    logic              begin_n;
    logic              oe_n;
  } bus_pins_t;
endpackage : ext_bus_pkg

// ===== src/ext_bus_port.sv
// external bus port: transfer sequencer, pin muxing and reset configuration capture
`timescale 1ns/1ps
`default_nettype none
module ext_bus_port (
  // clock and reset
  input  wire logic                          clk,
  input  wire logic                          srst,
  // internal request side
  input  wire logic                          req_valid,
  input  wire ext_bus_pkg::bus_req_t         req,
  output logic                               req_ready,
  output logic                               rsp_valid,
  output logic [ext_bus_pkg::DATA_W-1:0]     rsp_rdata,
  // sdram controller side
  input  wire logic                          sdram_active,
  input  wire logic [ext_bus_pkg::ADDR_W-1:0] sdram_addr,
  input  wire logic [ext_bus_pkg::LANES-1:0]  sdram_byte_mask,
  input  wire logic [ext_bus_pkg::DATA_W-1:0] sdram_wdata,
  input  wire logic [ext_bus_pkg::DATA_W-1:0] sdram_data_oe_n,
  output logic [ext_bus_pkg::DATA_W-1:0]     sdram_rdata,
  // pins
  input  wire logic                          sdram_type_select,
  input  wire logic                          reset_config_enable,
  input  wire logic                          transfer_done_ack_n,
  input  wire logic [ext_bus_pkg::DATA_W-1:0] data_in,
  output logic [ext_bus_pkg::DATA_W-1:0]     data_out,
  output logic [ext_bus_pkg::DATA_W-1:0]     data_oe_n,
  output logic [ext_bus_pkg::ADDR_W-1:0]     addr_out,
  output logic                               addr_oe_n,
  output logic [ext_bus_pkg::LANES-1:0]      byte_lane_strobe_n,
  output logic                               out_enable_n,
  output logic                               dir_read,
  output logic                               transfer_begin_strobe_n,
  output logic [ext_bus_pkg::NUM_CS-1:0]     ext_device_select_n,
  output logic                               ext_bus_clock_out,
  // configuration
  output logic [ext_bus_pkg::HALF_W-1:0]     config_word,
  output logic                               config_valid,
  output logic                               sdr_mode
);
  import ext_bus_pkg::*;

  typedef enum logic [3:0] {
    ST_IDLE   = 4'h1,
    ST_START  = 4'h2,
    ST_WAIT   = 4'h4,
    ST_FINISH = 4'h8
  } state_t;

  // **********************************************
  // input synchronisers
  // **********************************************
  logic [1:0]        ack_sync_reg;
  logic [1:0]        sel_sync_reg;
  logic [1:0]        reset_config_enable_sync_reg;
  logic [DATA_W-1:0] din_meta_reg;
  logic [DATA_W-1:0] din_sync_reg;

  // no reset: pins keep flowing through reset so the capture on release sees them
  always_ff @(posedge clk) begin
    ack_sync_reg  <= {ack_sync_reg[0], transfer_done_ack_n};
    sel_sync_reg  <= {sel_sync_reg[0], sdram_type_select};
    reset_config_enable_sync_reg <= {reset_config_enable_sync_reg[0], reset_config_enable};
    din_meta_reg  <= data_in;
    din_sync_reg  <= din_meta_reg;
  end

  wire logic ack_seen = ~ack_sync_reg[1];
  assign sdr_mode = sel_sync_reg[1];

  // **********************************************
  // bus clock: half of clk, with enable on its rising edge
  // **********************************************
  logic clk_div_reg;
  always_ff @(posedge clk) begin
    if (srst) clk_div_reg <= 1'b0;
    else      clk_div_reg <= ~clk_div_reg;
  end
  assign ext_bus_clock_out = clk_div_reg;
  wire logic bus_edge = ~clk_div_reg; // next clk edge raises the bus clock

  // **********************************************
  // reset configuration capture
  // **********************************************
  logic cfg_pending_reg;
  always_ff @(posedge clk) begin
    if (srst) begin
      cfg_pending_reg <= 1'b1;
      config_valid    <= 1'b0;
      config_word     <= '0;
    end else if (cfg_pending_reg) begin
      cfg_pending_reg <= 1'b0;
      config_valid    <= reset_config_enable_sync_reg[1];
      config_word     <= reset_config_enable_sync_reg[1] ? din_sync_reg[HALF_W-1:0] : '0;
    end
  end

  // **********************************************
  // transfer sequencer
  // **********************************************
  state_t    state_reg;
  bus_req_t  cur_reg;
  bus_pins_t pins_reg;

  function automatic logic [NUM_CS-1:0] cs_decode(input logic [2:0] idx);
    logic [NUM_CS-1:0] v;
    v = CS_IDLE_N;
    if (idx < 3'(NUM_CS)) v[idx] = 1'b0;
    return v;
  endfunction

  assign req_ready = (state_reg == ST_IDLE) && !sdram_active && bus_edge;

  always_ff @(posedge clk) begin
    if (srst) begin
      state_reg <= ST_IDLE;
      cur_reg   <= '0;
      rsp_valid <= 1'b0;
      rsp_rdata <= '0;
    end else begin
      rsp_valid <= 1'b0;
      case (state_reg)
        ST_IDLE: begin
          if (req_valid && req_ready) begin
            cur_reg <= req;
            // on-chip SRAM/cache never leave the chip
            state_reg <= (req.target == TGT_ONCHIP) ? ST_FINISH : ST_START;
          end
        end
        ST_START: if (bus_edge) state_reg <= ST_WAIT;
        ST_WAIT: begin
          if (bus_edge && ack_seen) begin
            if (cur_reg.read) rsp_rdata <= din_sync_reg;
            state_reg <= ST_FINISH;
          end
        end
        ST_FINISH: begin
          rsp_valid <= 1'b1;
          state_reg <= ST_IDLE;
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // **********************************************
  // external bus pin values
  // **********************************************
  wire logic active = (state_reg == ST_START) || (state_reg == ST_WAIT);
  always_ff @(posedge clk) begin
    if (srst) begin
      pins_reg <= '{addr: '0, cs_n: CS_IDLE_N, strobe: STROBE_IDLE_N,
                    dir_read: 1'b1, begin_n: 1'b1, oe_n: 1'b1};
    end else if (req_valid && req_ready && req.target != TGT_ONCHIP) begin
      pins_reg.addr     <= req.addr[ADDR_W-1:0];
      pins_reg.cs_n     <= (req.target == TGT_EXT) ? cs_decode(req.cs_index)
                                                   : CS_IDLE_N;
      pins_reg.strobe   <= ~req.lanes;
      pins_reg.dir_read <= req.read;
      pins_reg.begin_n  <= 1'b0;
      pins_reg.oe_n     <= ~req.read;
    end else if (state_reg == ST_START && bus_edge) begin
      pins_reg.begin_n <= 1'b1;
    end else if (state_reg == ST_WAIT && bus_edge && ack_seen) begin
      pins_reg.cs_n   <= CS_IDLE_N;
      pins_reg.strobe <= STROBE_IDLE_N;
      pins_reg.oe_n   <= 1'b1;
    end
  end

  // **********************************************
  // pin multiplexing between bus and sdram controller
  // **********************************************
  logic [DATA_W-1:0] bus_dout_reg;
  always_ff @(posedge clk) begin
    if (srst) bus_dout_reg <= '0;
    else if (req_valid && req_ready) bus_dout_reg <= req.wdata;
  end

  wire logic [DATA_W-1:0] bus_oe_n = (active && !cur_reg.read) ? '0 : '1;

  always_comb begin
    addr_out                = sdram_active ? sdram_addr : pins_reg.addr;
    addr_oe_n               = !(sdram_active || active);
    byte_lane_strobe_n      = sdram_active ? sdram_byte_mask : pins_reg.strobe;
    out_enable_n            = pins_reg.oe_n;
    dir_read                = pins_reg.dir_read;
    transfer_begin_strobe_n = pins_reg.begin_n;
    ext_device_select_n     = pins_reg.cs_n;
    sdram_rdata             = din_sync_reg;
    if (sdr_mode) begin
      // all lanes switch per access
      data_out  = sdram_active ? sdram_wdata : bus_dout_reg;
      data_oe_n = sdram_active ? sdram_data_oe_n : bus_oe_n;
    end else begin
      data_out  = {sdram_wdata[DATA_W-1:HALF_W], bus_dout_reg[HALF_W-1:0]};
      data_oe_n = {sdram_data_oe_n[DATA_W-1:HALF_W], bus_oe_n[HALF_W-1:0]};
    end
  end

  // **********************************************
  // checks
  // **********************************************
  one_select_a: assert property (@(posedge clk) disable iff (srst)
    $countones(~ext_device_select_n) <= 1) else $error("more than one select low");
  begin_pulse_a: assert property (@(posedge clk) disable iff (srst)
    $fell(transfer_begin_strobe_n) |=> !transfer_begin_strobe_n ##1 transfer_begin_strobe_n)
    else $error("begin strobe not one bus clock");
  clk_half_a: assert property (@(posedge clk) disable iff (srst)
    ext_bus_clock_out |=> !ext_bus_clock_out) else $error("bus clock not half rate");
  dir_oe_a: assert property (@(posedge clk) disable iff (srst)
    !out_enable_n |-> dir_read) else $error("output enable on write");
  ack_end_a: assert property (@(posedge clk) disable iff (srst)
    (state_reg == ST_WAIT && bus_edge && ack_seen) |=> ##1 rsp_valid)
    else $error("ack did not end cycle");
  sel_drop_a: assert property (@(posedge clk) disable iff (srst)
    (state_reg == ST_WAIT && bus_edge && ack_seen) |=> &ext_device_select_n)
    else $error("select held after ack");
  onchip_quiet_a: assert property (@(posedge clk) disable iff (srst)
    (req_valid && req_ready && req.target == TGT_ONCHIP) |=> transfer_begin_strobe_n)
    else $error("on-chip access reached pins");
  ddr_split_a: assert property (@(posedge clk) disable iff (srst)
    !sdr_mode |-> data_oe_n[DATA_W-1:HALF_W] == sdram_data_oe_n[DATA_W-1:HALF_W])
    else $error("upper lanes not dedicated");
  write_drive_a: assert property (@(posedge clk) disable iff (srst)
    (state_reg == ST_WAIT && !cur_reg.read && !sdram_active) |-> data_oe_n[HALF_W-1:0] == '0)
    else $error("write data not driven");
endmodule : ext_bus_port
`default_nettype wire

// ===== tb/ext_dev_model.sv
// far-side device model: acknowledges bus cycles and serves read data
`timescale 1ns/1ps
`default_nettype none
module ext_dev_model (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        srst,
  // bench settings
  input  wire logic [3:0]  wait_cyc,
  input  wire logic [31:0] rd_val,
  input  wire logic [15:0] cfg_val,
  // bus pins
  input  wire logic [5:0]  sel_n,
  input  wire logic [3:0]  strobe_n,
  input  wire logic        oe_n,
  input  wire logic        begin_n,
  input  wire logic [31:0] dout,
  input  wire logic [31:0] dout_oe_n,
  output logic             ack_n,
  output logic [31:0]      din,
  output logic [31:0]      wr_seen
);
  logic        busy;
  logic [3:0]  cnt;
  logic [31:0] last = 32'h0;
  logic [31:0] lane_m;
  assign lane_m = {{8{~strobe_n[0]}}, {8{~strobe_n[1]}}, {8{~strobe_n[2]}}, {8{~strobe_n[3]}}};
  // ack held until select and strobes drop; idle level is the pull-up
  always_ff @(posedge clk) begin
    if (srst || (!ack_n && &sel_n && &strobe_n)) begin
      busy  <= 1'b0;
      ack_n <= 1'b1;
    end else if (!busy && !begin_n) begin
      busy <= 1'b1;
      cnt  <= 4'h0;
    end else if (busy && ack_n) begin
      cnt <= cnt + 4'h1;
      if (cnt >= wait_cyc) begin
        ack_n   <= 1'b0;
        wr_seen <= dout & ~dout_oe_n & lane_m;
      end
    end
  end
  always_ff @(posedge clk) last <= din;
  // released bus shows a changing pattern, not the last value
  assign din = !oe_n ? rd_val : srst ? {~last[31:16], cfg_val} : ~last;
endmodule : ext_dev_model
`default_nettype wire

// ===== tb/tb.sv
// self-checking bench for the external bus port
`timescale 1ns/1ps
`default_nettype none
module tb;
  import ext_bus_pkg::*;
  localparam logic [15:0] CFG = 16'h5a3c;
  typedef struct packed {logic [1:0] kind; logic [31:0] d;} note_t;
  logic clk = 1'b0, srst = 1'b1, req_valid = 1'b0, sd_act = 1'b0, sel = 1'b1, rcfg = 1'b1, b;
  bus_req_t    req = '0;
  logic [23:0] sd_addr = '0, addr_out;
  logic [3:0]  sd_mask = '0, wait_cyc = '0, strobe_n;
  logic [31:0] rd_val = '0, rsp_rdata, data_out, data_oe_n, din, wr_seen;
  logic [31:0] sd_wdata = '0, sd_oe_n = '1, sd_rdata;
  logic        req_ready, rsp_valid, ack_n, oe_n, dir_read, begin_n, bclk, cfg_valid, sdr_mode;
  logic        aoe_n;
  logic [5:0]  sel_n;
  logic [15:0] cfg_word;
  note_t       q[$];
  note_t       nt;
  int          seed = 32'hf315, fail_count = 0, tests_run = 0, n;
  always #50 clk = ~clk;
  ext_bus_port i_ext_bus_port (.clk(clk), .srst(srst), .req_valid(req_valid), .req(req),
    .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .sdram_active(sd_act),
    .sdram_addr(sd_addr), .sdram_byte_mask(sd_mask), .sdram_wdata(sd_wdata),
    .sdram_data_oe_n(sd_oe_n), .sdram_rdata(sd_rdata), .sdram_type_select(sel),
    .reset_config_enable(rcfg), .transfer_done_ack_n(ack_n), .data_in(din),
    .data_out(data_out), .data_oe_n(data_oe_n), .addr_out(addr_out), .addr_oe_n(aoe_n),
    .byte_lane_strobe_n(strobe_n), .out_enable_n(oe_n), .dir_read(dir_read),
    .transfer_begin_strobe_n(begin_n), .ext_device_select_n(sel_n), .ext_bus_clock_out(bclk),
    .config_word(cfg_word), .config_valid(cfg_valid), .sdr_mode(sdr_mode));
  ext_dev_model i_ext_dev_model (.clk(clk), .srst(srst), .wait_cyc(wait_cyc), .rd_val(rd_val),
    .cfg_val(CFG), .sel_n(sel_n), .strobe_n(strobe_n), .oe_n(oe_n), .begin_n(begin_n),
    .dout(data_out), .dout_oe_n(data_oe_n), .ack_n(ack_n), .din(din), .wr_seen(wr_seen));
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (exp !== got) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic finish_test;
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : finish_test
  task automatic bound(input logic ok);
    if (ok !== 1'b1) begin
      $display("[FAIL] handshake expected 1 seen timeout");
      fail_count++;
      finish_test();
    end
  endtask : bound
  // ******************************************************
  // one bus transfer: drive, note the result, check the pins
  // ******************************************************
  task automatic xfer(input logic [31:0] a, input logic [31:0] w, input logic [3:0] ln,
                      input logic rd, input logic [2:0] cs, input target_t t);
    logic ext;
    ext = (t != TGT_ONCHIP);
    @(posedge clk);
    if (!ext) q.push_back({2'h2, 32'h0});
    else if (rd) q.push_back({2'h0, rd_val});
    else q.push_back({2'h1, (sel ? w : {sd_wdata[31:16] & ~sd_oe_n[31:16], w[15:0]})
                            & {{8{ln[0]}}, {8{ln[1]}}, {8{ln[2]}}, {8{ln[3]}}}});
    req <= '{addr: a, wdata: w, lanes: ln, read: rd, cs_index: cs, target: t};
    req_valid <= 1'b1;
    n = 0;
    do begin @(negedge clk); n++; end while (!req_ready && n < 50);
    bound(req_ready);
    @(posedge clk);
    req_valid <= 1'b0;
    @(posedge clk);
    #1;
    chk("strobes", {28'h0, ext ? ~ln : STROBE_IDLE_N}, {28'h0, strobe_n});
    chk("select", {26'h0, t == TGT_EXT ? ~(6'h1 << cs) : CS_IDLE_N}, {26'h0, sel_n});
    chk("begin", {31'h0, !ext}, {31'h0, begin_n});
    chk("addr oe", {31'h0, !ext}, {31'h0, aoe_n});
    if (ext) begin
      chk("addr", {8'h0, a[23:0]}, {8'h0, addr_out});
      chk("dir", {31'h0, rd}, {31'h0, dir_read});
      chk("oe", {31'h0, !rd}, {31'h0, oe_n});
      if (!rd) chk("drive", {sel ? 16'h0 : sd_oe_n[31:16], 16'h0}, data_oe_n);
      @(negedge clk);
      chk("begin held", 32'h0, {31'h0, begin_n});
      @(posedge clk);
      #1;
      chk("begin end", 32'h1, {31'h0, begin_n});
      if (rd) chk("sdram rdata", rd_val, sd_rdata);
    end
    n = 0;
    do begin @(negedge clk); n++; end while (!rsp_valid && n < 50);
    bound(rsp_valid);
    chk("release", {26'h0, CS_IDLE_N}, {26'h0, sel_n});
    @(posedge clk);
  endtask : xfer
  always @(negedge clk) if (rsp_valid === 1'b1) begin
    if (q.size() == 0) begin
      fail_count++;
      $display("[FAIL] response expected none seen 1");
    end else begin
      nt = q.pop_front();
      if (nt.kind == 2'h0) chk("rdata", nt.d, rsp_rdata);
      else if (nt.kind == 2'h1) chk("wdata", nt.d, wr_seen);
    end
  end
  initial begin
    repeat (12) @(posedge clk);
    srst <= 1'b0;
    repeat (4) @(posedge clk);
    #1;
    chk("config", {16'h0, CFG}, {16'h0, cfg_word});
    chk("config valid", 32'h1, {31'h0, cfg_valid});
    chk("sdr mode", 32'h1, {31'h0, sdr_mode});
    repeat (3) begin
      b = bclk;
      @(posedge clk);
      #1;
      chk("bus clock", {31'h0, ~b}, {31'h0, bclk});
    end
    for (int i = 0; i < 6; i++) begin
      wait_cyc <= 4'(i * 2);
      rd_val <= $random(seed);
      xfer($random(seed), $random(seed), i < 4 ? 4'h1 << i : 4'h9, 1'b0, 3'(i), TGT_EXT);
      xfer($random(seed), 32'h0, 4'hf, 1'b1, 3'(i), TGT_EXT);
    end
    xfer($random(seed), $random(seed), 4'h6, 1'b0, 3'h0, TGT_PERIPH);
    xfer($random(seed), $random(seed), 4'hf, 1'b0, 3'h1, TGT_ONCHIP);
    $display("test bus cycles done");
    sel <= 1'b0;
    sd_wdata <= $random(seed);
    sd_oe_n <= $random(seed);
    repeat (4) @(posedge clk);
    #1;
    chk("ddr mode", 32'h0, {31'h0, sdr_mode});
    chk("ddr upper", {16'h0, sd_wdata[31:16]}, {16'h0, data_out[31:16]});
    chk("ddr upper oe", {16'h0, sd_oe_n[31:16]}, {16'h0, data_oe_n[31:16]});
    xfer($random(seed), $random(seed), 4'hf, 1'b0, 3'h2, TGT_EXT);
    sel <= 1'b1;
    sd_addr <= 24'($random(seed));
    sd_mask <= 4'($random(seed));
    sd_act <= 1'b1;
    repeat (3) @(posedge clk);
    #1;
    chk("sdram addr", {8'h0, sd_addr}, {8'h0, addr_out});
    chk("sdram mask", {28'h0, sd_mask}, {28'h0, strobe_n});
    chk("sdram addr oe", 32'h0, {31'h0, aoe_n});
    chk("sdram data", sd_wdata, data_out);
    chk("sdram data oe", sd_oe_n, data_oe_n);
    @(posedge clk);
    sd_act <= 1'b0;
    rcfg <= 1'b0;
    srst <= 1'b1;
    repeat (12) @(posedge clk);
    srst <= 1'b0;
    repeat (4) @(posedge clk);
    #1;
    chk("config off", 32'h0, {16'h0, cfg_word});
    chk("config valid off", 32'h0, {31'h0, cfg_valid});
    chk("pending notes", 32'h0, q.size());
    $display("test modes and sharing done");
    finish_test();
  end
endmodule : tb
`default_nettype wire
